// [include/pbm_pkg.sv]
// Purpose: shared constants and types of the pushbutton reset and wake manager
// Assumes: 200 MHz system clock; slow timers count a 1 ms tick
// Notes:   long counts are overridable top-level parameters
package pbm_pkg;
    localparam int CLK_HZ           = 200_000_000;
    localparam int MS_CYC           = CLK_HZ / 1000;
    localparam int INT_PULSE_US     = 128;
    localparam int INT_PULSE_CYC    = INT_PULSE_US * (CLK_HZ / 1_000_000);
    localparam int DEGLITCH_MS      = 10;
    localparam int DEGLITCH_CYC     = DEGLITCH_MS * MS_CYC;
    localparam int VIN_PULSE_MIN_MS = 500;
    localparam int VIN_WINDOW_MS    = 8000;
    localparam int VIN_PULSE_COUNT  = 3;
    localparam int ADAPTER_WD_MS    = 15000;
    localparam int SHIP_WAKE_MS     = 1000;
    localparam int AUTOWAKE_MS      = 500;
    localparam int MSW              = 16;

    localparam logic [1:0] LP_NONE = 2'h0;
    localparam logic [1:0] LP_HW   = 2'h1;
    localparam logic [1:0] LP_SHIP = 2'h2;

    localparam logic [3:0] RAIL_A = 4'h1;
    localparam logic [3:0] RAIL_B = 4'h2;
    localparam logic [3:0] RAIL_C = 4'h4;
    localparam logic [3:0] RAIL_D = 4'h8;

    typedef struct packed {
        logic [MSW-1:0] short_one_ms;
        logic [MSW-1:0] short_two_ms;
        logic [MSW-1:0] long_ms;
        logic [MSW-1:0] warn_ms;
    } pbm_press_cfg_t;

    typedef struct packed {
        logic short_one;
        logic short_two;
        logic warn;
    } pbm_evt_t;

    typedef struct packed {
        logic [3:0] rail_en;
        logic       battery_switch;
        logic       input_switch;
        logic       system_rail_pulldown;
    } pbm_power_t;

    typedef enum logic [3:0] {
        ST_RUN      = 4'h0,
        ST_PD_WAIT  = 4'h1,
        ST_PD_C     = 4'h2,
        ST_PD_B     = 4'h3,
        ST_PD_A     = 4'h4,
        ST_PD_OFF   = 4'h5,
        ST_AUTOWAKE = 4'h6,
        ST_RESTORE  = 4'h7,
        ST_RECONN   = 4'h8,
        ST_SHIP     = 4'h9
    } pbm_state_t;
endpackage

// [rtl/pbm_debounce.sv]
// Purpose: synchronise and deglitch the pushbutton pin
// Assumes: pin idles high, low means pressed
// Notes:   output changes only after STABLE_CYC equal samples
`timescale 1ns/1ps
module pbm_debounce #(
    parameter int STABLE_CYC = pbm_pkg::DEGLITCH_CYC
) (
    input  wire logic sys_clk,
    input  wire logic arst_n,
    input  wire logic pin_raw,
    output logic      pressed
);
    localparam int CW = $clog2(STABLE_CYC + 1);
    initial begin
        if (STABLE_CYC < 1) $error("STABLE_CYC must be at least 1");
    end

    logic          sync1_r;
    logic          sync2_r;
    logic [CW-1:0] cnt_r;
    logic          pressed_r;
    wire           raw_press = ~sync2_r;
    wire           differs   = raw_press != pressed_r;
    wire           settled   = cnt_r == CW'(STABLE_CYC - 1);

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
        end else begin
            sync1_r <= pin_raw;
            sync2_r <= sync1_r;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r     <= '0;
            pressed_r <= 1'b0;
        end else if (!differs) begin
            cnt_r <= '0;
        end else if (settled) begin
            cnt_r     <= '0;
            pressed_r <= raw_press;
        end else begin
            cnt_r <= cnt_r + CW'(1);
        end
    end

    assign pressed = pressed_r;
endmodule // pbm_debounce

// [rtl/pbm_int_pulse.sv]
// Purpose: fixed-width low pulse on the open-drain interrupt pin
// Assumes: trig is a one-cycle event
// Notes:   a new event during a pulse restarts the full width
`timescale 1ns/1ps
module pbm_int_pulse #(
    parameter int LEN_CYC = pbm_pkg::INT_PULSE_CYC
) (
    input  wire logic sys_clk,
    input  wire logic arst_n,
    input  wire logic trig,
    output logic      int_oe
);
    localparam int CW = $clog2(LEN_CYC + 1);
    initial begin
        if (LEN_CYC < 2) $error("LEN_CYC must be at least 2");
    end

    logic [CW-1:0] cnt_r;
    logic          oe_r;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r <= '0;
            oe_r  <= 1'b0;
        end else if (trig) begin
            cnt_r <= CW'(LEN_CYC - 1);
            oe_r  <= 1'b1;
        end else if (cnt_r != '0) begin
            cnt_r <= cnt_r - CW'(1);
        end else begin
            oe_r <= 1'b0;
        end
    end

    assign int_oe = oe_r;

    a_pulse_load : assert property (@(posedge sys_clk) disable iff (!arst_n)
        trig |=> oe_r && cnt_r == CW'(LEN_CYC - 1))
        else $error("interrupt pulse not loaded");
endmodule // pbm_int_pulse

// [rtl/pbm_wake_manager.sv]
// Purpose: pushbutton wake, press events, reset sources and power cycle
// Assumes: inputs synchronous except the pushbutton pin
// Notes:   slow timers run on a shared 1 ms tick, so they carry up to
//          one tick of phase jitter
`timescale 1ns/1ps
module pbm_wake_manager #(
    parameter int MS_CYC         = pbm_pkg::MS_CYC,
    parameter int DEGLITCH_CYC   = pbm_pkg::DEGLITCH_CYC,
    parameter int INT_PULSE_CYC  = pbm_pkg::INT_PULSE_CYC,
    parameter int VIN_MIN_MS     = pbm_pkg::VIN_PULSE_MIN_MS,
    parameter int VIN_WINDOW_MS  = pbm_pkg::VIN_WINDOW_MS,
    parameter int ADAPTER_WD_MS  = pbm_pkg::ADAPTER_WD_MS,
    parameter int SHIP_WAKE_MS   = pbm_pkg::SHIP_WAKE_MS,
    parameter int AUTOWAKE_MS    = pbm_pkg::AUTOWAKE_MS
) (
    input  wire logic                    sys_clk,
    input  wire logic                    arst_n,
    input  wire logic                    pushbutton_input,
    output logic                         pushbutton_pullup_en,
    input  wire pbm_pkg::pbm_press_cfg_t press_cfg,
    input  wire logic [1:0]              long_press_action_select,
    input  wire pbm_pkg::pbm_evt_t       irq_mask,
    input  wire logic                    clear_short_one,
    input  wire logic                    clear_short_two,
    input  wire logic                    input_power_good,
    input  wire logic                    input_power_good_status,
    input  wire logic                    battery_above_uvlo,
    input  wire logic                    battery_depletion_fault,
    input  wire logic                    reset_needs_input_power,
    input  wire logic                    adapter_timeout_enable,
    input  wire logic                    host_ack,
    input  wire logic                    soft_reset_req,
    input  wire logic [6:0]              seq_delay_ms,
    input  wire logic [3:0]              rail_cfg_en,
    output logic                         short_press_one_flag,
    output logic                         short_press_two_flag,
    output pbm_pkg::pbm_power_t          power,
    output logic                         sequence_power_good,
    output logic                         ship_mode,
    output logic                         hard_power_cycle,
    output logic                         reg_restore_all,
    output logic                         soft_reset_strobe,
    output logic                         int_out,
    output logic                         int_oe
);
    localparam int MSW = pbm_pkg::MSW;
    localparam int PW  = $clog2(MS_CYC + 1);
    initial begin
        if (MS_CYC < 2) $error("MS_CYC must be at least 2");
        if (VIN_WINDOW_MS >= 2**MSW || ADAPTER_WD_MS >= 2**MSW) $error("ms count too wide");
        if (SHIP_WAKE_MS < 1 || AUTOWAKE_MS < 1 || VIN_MIN_MS < 1) $error("ms count below one");
    end

    function automatic logic hit(input logic [MSW-1:0] cnt, input logic [MSW-1:0] thr);
        hit = thr != '0 && ({1'b0, cnt} + 17'h00001) == {1'b0, thr};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // timebase and pin
    logic [PW-1:0] pre_r;
    wire           ms_tick = pre_r == PW'(MS_CYC - 1);
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) pre_r <= '0;
        else pre_r <= ms_tick ? '0 : pre_r + PW'(1);
    end

    logic pressed;
    pbm_debounce #(.STABLE_CYC(DEGLITCH_CYC)) u_deb (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .pin_raw (pushbutton_input),
        .pressed (pressed)
    );

    ////////////////////////////////////////////////////////////////////////
    // press timing
    pbm_pkg::pbm_state_t     state_r;
    pbm_pkg::pbm_state_t     state_nxt;
    pbm_pkg::pbm_press_cfg_t cfg_r;
    logic                    pressed_d_r;
    logic [MSW-1:0]          press_ms_r;
    wire press_start = pressed && !pressed_d_r;
    wire counting    = pressed && pressed_d_r && ms_tick;
    wire in_run      = state_r == pbm_pkg::ST_RUN;
    wire in_ship     = state_r == pbm_pkg::ST_SHIP;
    wire [MSW-1:0] warn_at = cfg_r.warn_ms < cfg_r.long_ms ? cfg_r.long_ms - cfg_r.warn_ms : '0;
    wire ev_short1 = in_run && counting && hit(press_ms_r, cfg_r.short_one_ms);
    wire ev_short2 = in_run && counting && hit(press_ms_r, cfg_r.short_two_ms);
    wire ev_warn   = in_run && counting && hit(press_ms_r, warn_at);
    wire ev_long   = in_run && counting && hit(press_ms_r, cfg_r.long_ms);
    wire ship_wake = in_ship && counting && battery_above_uvlo
                     && hit(press_ms_r, MSW'(SHIP_WAKE_MS));

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pressed_d_r <= 1'b0;
            press_ms_r  <= '0;
            cfg_r       <= '0;
        end else begin
            pressed_d_r <= pressed;
            if (press_start) cfg_r <= press_cfg;
            if (!pressed || press_start) press_ms_r <= '0;
            else if (counting && press_ms_r != '1) press_ms_r <= press_ms_r + MSW'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // flags and interrupt
    logic flag1_r;
    logic flag2_r;
    wire  irq_trig = (ev_short1 && !irq_mask.short_one) || (ev_short2 && !irq_mask.short_two)
                     || (ev_warn && !irq_mask.warn);
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            flag1_r <= 1'b0;
            flag2_r <= 1'b0;
        end else begin
            flag1_r <= ev_short1 | (flag1_r & ~clear_short_one);
            flag2_r <= ev_short2 | (flag2_r & ~clear_short_two);
        end
    end

    pbm_int_pulse #(.LEN_CYC(INT_PULSE_CYC)) u_int (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .trig    (irq_trig),
        .int_oe  (int_oe)
    );

    ////////////////////////////////////////////////////////////////////////
    // input pulse detector
    logic           vin_d_r;
    logic [MSW-1:0] vin_hi_r;
    logic [MSW-1:0] win_r;
    logic           win_act_r;
    logic [2:0]     vin_cnt_r;
    wire vin_rise  = input_power_good && !vin_d_r;
    wire vin_qual  = !input_power_good && vin_d_r && vin_hi_r >= MSW'(VIN_MIN_MS);
    wire win_end   = win_act_r && ms_tick && win_r == MSW'(VIN_WINDOW_MS - 1);
    wire vin_reset = win_end && vin_cnt_r == 3'(pbm_pkg::VIN_PULSE_COUNT);
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            vin_d_r   <= 1'b0;
            vin_hi_r  <= '0;
            win_r     <= '0;
            win_act_r <= 1'b0;
            vin_cnt_r <= '0;
        end else begin
            vin_d_r <= input_power_good;
            if (!input_power_good) vin_hi_r <= '0;
            else if (ms_tick && vin_hi_r != MSW'(VIN_MIN_MS)) vin_hi_r <= vin_hi_r + MSW'(1);
            if (win_end) begin
                win_act_r <= 1'b0;
            end else if (vin_rise && !win_act_r) begin
                win_act_r <= 1'b1;
                win_r     <= '0;
                vin_cnt_r <= '0;
            end else if (win_act_r && ms_tick) begin
                win_r <= win_r + MSW'(1);
            end
            if (win_act_r && !win_end && vin_qual && vin_cnt_r != 3'h7)
                vin_cnt_r <= vin_cnt_r + 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // adapter watchdog
    logic           stat_d_r;
    logic           wd_act_r;
    logic [MSW-1:0] wd_r;
    wire wd_end = wd_act_r && ms_tick && wd_r == MSW'(ADAPTER_WD_MS - 1);
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            stat_d_r <= 1'b0;
            wd_act_r <= 1'b0;
            wd_r     <= '0;
        end else begin
            stat_d_r <= input_power_good_status;
            if (host_ack || !adapter_timeout_enable || !input_power_good_status || wd_end) begin
                wd_act_r <= 1'b0;
            end else if (input_power_good_status && !stat_d_r) begin
                wd_act_r <= 1'b1;
                wd_r     <= '0;
            end else if (wd_act_r && ms_tick) begin
                wd_r <= wd_r + MSW'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reset requests
    logic hw_pend_r;
    logic ship_tgt_r;
    wire  lp_hw    = ev_long && long_press_action_select == pbm_pkg::LP_HW;
    wire  lp_ship  = ev_long && long_press_action_select == pbm_pkg::LP_SHIP;
    wire  hw_ok    = !reset_needs_input_power || input_power_good;
    wire  hw_start = in_run && hw_pend_r && hw_ok;
    wire  pd_start = hw_start || (in_run && lp_ship);
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            hw_pend_r  <= 1'b0;
            ship_tgt_r <= 1'b0;
        end else begin
            hw_pend_r <= lp_hw || vin_reset || wd_end || (hw_pend_r && !hw_start);
            if (pd_start) ship_tgt_r <= !hw_start;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // power cycle sequencer
    logic [MSW-1:0] step_r;
    wire [MSW-1:0] step_len = state_r == pbm_pkg::ST_AUTOWAKE ? MSW'(AUTOWAKE_MS)
                              : {9'h000, seq_delay_ms} + MSW'(1);
    wire step_done = ms_tick && step_r == step_len - MSW'(1);

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            pbm_pkg::ST_RUN:      if (pd_start) state_nxt = pbm_pkg::ST_PD_WAIT;
            pbm_pkg::ST_PD_WAIT:  if (step_done) state_nxt = pbm_pkg::ST_PD_C;
            pbm_pkg::ST_PD_C:     if (step_done) state_nxt = pbm_pkg::ST_PD_B;
            pbm_pkg::ST_PD_B:     if (step_done) state_nxt = pbm_pkg::ST_PD_A;
            pbm_pkg::ST_PD_A:     if (step_done) state_nxt = pbm_pkg::ST_PD_OFF;
            pbm_pkg::ST_PD_OFF:   if (step_done)
                state_nxt = ship_tgt_r ? pbm_pkg::ST_SHIP : pbm_pkg::ST_AUTOWAKE;
            pbm_pkg::ST_AUTOWAKE: if (step_done) state_nxt = pbm_pkg::ST_RESTORE;
            pbm_pkg::ST_RESTORE:  state_nxt = pbm_pkg::ST_RECONN;
            pbm_pkg::ST_RECONN:   state_nxt = pbm_pkg::ST_RUN;
            pbm_pkg::ST_SHIP:     if (input_power_good || ship_wake) state_nxt = pbm_pkg::ST_RECONN;
            default:              state_nxt = pbm_pkg::ST_RUN;
        endcase
    end

    pbm_pkg::pbm_power_t pwr_r;
    logic                seq_pg_r;
    logic                soft_r;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r  <= pbm_pkg::ST_RUN;
            step_r   <= '0;
            pwr_r    <= '{rail_en: 4'h0, battery_switch: 1'b1, input_switch: 1'b1,
                          system_rail_pulldown: 1'b0};
            seq_pg_r <= 1'b0;
            soft_r   <= 1'b0;
        end else begin
            state_r <= state_nxt;
            soft_r  <= soft_reset_req;
            if (state_nxt != state_r) step_r <= '0;
            else if (ms_tick) step_r <= step_r + MSW'(1);
            unique case (state_r)
                pbm_pkg::ST_RUN: begin
                    pwr_r.rail_en <= rail_cfg_en;
                    seq_pg_r      <= !pd_start;
                end
                pbm_pkg::ST_PD_WAIT: if (step_done) pwr_r.rail_en <= pwr_r.rail_en & ~pbm_pkg::RAIL_D;
                pbm_pkg::ST_PD_C:    if (step_done) pwr_r.rail_en <= pwr_r.rail_en & ~pbm_pkg::RAIL_C;
                pbm_pkg::ST_PD_B:    if (step_done) pwr_r.rail_en <= pwr_r.rail_en & ~pbm_pkg::RAIL_B;
                pbm_pkg::ST_PD_A:    if (step_done) pwr_r.rail_en <= pwr_r.rail_en & ~pbm_pkg::RAIL_A;
                pbm_pkg::ST_PD_OFF: if (step_done) begin
                    pwr_r.battery_switch       <= 1'b0;
                    pwr_r.input_switch         <= 1'b0;
                    pwr_r.system_rail_pulldown <= 1'b1;
                end
                pbm_pkg::ST_AUTOWAKE: if (step_done) pwr_r.system_rail_pulldown <= 1'b0;
                pbm_pkg::ST_RECONN: begin
                    pwr_r.system_rail_pulldown <= 1'b0;
                    pwr_r.battery_switch       <= !battery_depletion_fault;
                    pwr_r.input_switch         <= input_power_good;
                end
                default: ;
            endcase
        end
    end

    assign pushbutton_pullup_en = 1'b1;
    assign short_press_one_flag = flag1_r;
    assign short_press_two_flag = flag2_r;
    assign power                = pwr_r;
    assign sequence_power_good  = seq_pg_r;
    assign ship_mode            = in_ship;
    assign hard_power_cycle     = !in_run && !in_ship;
    assign reg_restore_all      = state_r == pbm_pkg::ST_RESTORE;
    assign soft_reset_strobe    = soft_r;
    assign int_out              = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    // rails d, c, b off on entry to the last step, which lasts at least a tick
    sequence s_pd_tail;
        state_r == pbm_pkg::ST_PD_A && (pwr_r.rail_en & ~pbm_pkg::RAIL_A) == 4'h0
            ##1 state_r == pbm_pkg::ST_PD_A;
    endsequence

    a_short_irq_out : assert property ((ev_short1 && !irq_mask.short_one) |=> int_oe)
        else $error("unmasked short press gave no pulse");
    a_masked_quiet : assert property ((!irq_trig && !int_oe) |=> !int_oe)
        else $error("pulse without unmasked event");
    a_ship_vin_exit : assert property ((in_ship && input_power_good) |=> state_r == pbm_pkg::ST_RECONN)
        else $error("ship mode kept with input power");
    a_reset_gate : assert property ((hw_start && reset_needs_input_power) |-> input_power_good)
        else $error("reset began without input power");
    a_pd_order : assert property ((state_r == pbm_pkg::ST_PD_B && step_done) |=> s_pd_tail)
        else $error("power-down order broken");
    a_release_cancel : assert property ($fell(pressed) |=> press_ms_r == '0 && !ev_long)
        else $error("press timer kept after release");
    a_triple_reset : assert property (vin_reset |=> hw_pend_r)
        else $error("three pulses gave no reset");
    a_wd_reset : assert property (wd_end |=> hw_pend_r)
        else $error("watchdog expiry gave no reset");
    a_restore_then : assert property (reg_restore_all |=> state_r == pbm_pkg::ST_RECONN ##1 in_run)
        else $error("restore not followed by reconnect");
    a_soft_strobe : assert property (soft_reset_req |=> soft_reset_strobe)
        else $error("soft reset not strobed");
endmodule // pbm_wake_manager

// [testbench/pbm_host_model.sv]
// Purpose: host model, watches the interrupt line and answers the adapter watchdog
// Assumes: line pulled up, low while the device drives it
// Notes:   answers 800 cycles after the status rises, when enabled
`timescale 1ns/1ps
module pbm_host_model (
    input  wire logic sys_clk,
    input  wire logic int_line,
    input  wire logic pg_status,
    input  wire logic ack_en,
    output logic      host_ack,
    output int        pulse_cnt,
    output int        last_w
);
    int   w = 0, wait_c = 0, cnt_r = 0, lw_r = 0;
    logic prev_l = 1'b1, prev_s = 1'b0, ack_r = 1'b0;
    // low width counted in clock edges
    always @(posedge sys_clk) begin
        w <= int_line ? 0 : w + 1;
        if (int_line && !prev_l) begin
            cnt_r <= cnt_r + 1;
            lw_r  <= w;
        end
        prev_l <= int_line;
    end
    always @(posedge sys_clk) begin
        prev_s <= pg_status;
        ack_r  <= (wait_c == 1);
        if (pg_status && !prev_s && ack_en) wait_c <= 800;
        else if (wait_c > 0) wait_c <= wait_c - 1;
    end
    assign host_ack  = ack_r;
    assign pulse_cnt = cnt_r;
    assign last_w    = lw_r;
endmodule // pbm_host_model

// [testbench/test_pbm_wake_manager.sv]
// Purpose: self-checking bench of the pushbutton reset and wake manager
// Assumes: shortened timers, 1 ms tick = 20 cycles
// Notes:   rail settings and step delay drawn from an lfsr
`timescale 1ns/1ps
module test_pbm_wake_manager;
    logic sys_clk = 1'b0, arst_n = 1'b0, pb = 1'b1, c1 = 1'b0, c2 = 1'b0, pg = 1'b1, pgs = 1'b0;
    logic bat_ok = 1'b1, need_in = 1'b0, wd_en = 1'b0, srq = 1'b0, ack_en = 1'b0, seen, rst_seen = 1'b0;
    logic [1:0] act = 2'h0;
    logic       dep = 1'b0;
    logic [6:0] sdly = 7'h0;
    logic [3:0] rcfg = 4'hF;
    logic [31:0] rnd = 32'h22CA2891;
    pbm_pkg::pbm_press_cfg_t cfg = '0;
    pbm_pkg::pbm_evt_t       msk = '0;
    pbm_pkg::pbm_power_t     pwr;
    logic f1, f2, spg, ship, hpc, rall, sstb, io, ioe, pu, ack;
    int   mismatches = 0, check_count = 0, pc, lw, n0;
    wire  int_line = ioe ? io : 1'b1;

    pbm_wake_manager #(.MS_CYC(20), .DEGLITCH_CYC(4), .INT_PULSE_CYC(16), .VIN_MIN_MS(5), .VIN_WINDOW_MS(80),
        .ADAPTER_WD_MS(150), .SHIP_WAKE_MS(10), .AUTOWAKE_MS(5)) i_pbm_wake_manager (
        .sys_clk(sys_clk), .arst_n(arst_n), .pushbutton_input(pb), .pushbutton_pullup_en(pu),
        .press_cfg(cfg), .long_press_action_select(act), .irq_mask(msk), .clear_short_one(c1),
        .clear_short_two(c2), .input_power_good(pg), .input_power_good_status(pgs),
        .battery_above_uvlo(bat_ok), .battery_depletion_fault(dep), .reset_needs_input_power(need_in),
        .adapter_timeout_enable(wd_en), .host_ack(ack), .soft_reset_req(srq), .seq_delay_ms(sdly),
        .rail_cfg_en(rcfg), .short_press_one_flag(f1), .short_press_two_flag(f2), .power(pwr),
        .sequence_power_good(spg), .ship_mode(ship), .hard_power_cycle(hpc), .reg_restore_all(rall),
        .soft_reset_strobe(sstb), .int_out(io), .int_oe(ioe));
    pbm_host_model i_pbm_host_model (.sys_clk(sys_clk), .int_line(int_line), .pg_status(pgs),
        .ack_en(ack_en), .host_ack(ack), .pulse_cnt(pc), .last_w(lw));

    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) if (rall === 1'b1) rst_seen <= 1'b1;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %0h, wanted %0h", $time, got, exp);
        end
    endtask
    // records any power cycle seen during a span of lim cycles set by the caller
    task automatic wait_hpc(input int lim);
        seen = 1'b0;
        repeat (lim) begin
            tick(1);
            if (hpc === 1'b1) seen = 1'b1;
        end
    endtask
    task automatic vin(input int n);
        pg = 1'b0;
        tick(40);
        repeat (n) begin
            pg = 1'b1;
            tick(120);
            pg = 1'b0;
            tick(40);
        end
        pg = 1'b1;
        wait_hpc(2500);
    endtask
    task automatic stop_test;
        $display("checks %0d, mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge sys_clk);
        mismatches++;
        stop_test();
    end
    initial begin
        tick(8);
        arst_n = 1'b1;
        tick(2);
        check(pu, 1'b1);
        check(io, 1'b0);
        cfg = '{16'h0002, 16'h0004, 16'h0000, 16'h0000};
        n0 = pc;
        pb = 1'b0;
        tick(20);
        cfg.short_one_ms = 16'h00FF;
        tick(120);
        pb = 1'b1;
        tick(60);
        check(f1, 1'b1);
        check(f2, 1'b1);
        check(pc - n0, 2);
        check(lw, 16);
        check(hpc, 1'b0);
        $display("short press test done");
        {c1, c2, msk.short_one, cfg.short_one_ms} = {3'h7, 16'h0002};
        tick(1);
        {c1, c2, n0} = {2'h0, pc};
        pb = 1'b0;
        tick(60);
        pb = 1'b1;
        tick(60);
        check({f1, f2}, 2'h2);
        msk = '0;
        tick(40);
        check(pc - n0, 0);
        $display("mask test done");
        rnd = lfsr(rnd);
        {rcfg, sdly, act, cfg} = {rnd[3:0], 5'h0, rnd[5:4], pbm_pkg::LP_HW, 32'h0, 16'h0008, 16'h0003};
        n0 = pc;
        pb = 1'b0;
        tick(180);
        pb = 1'b1;
        check(pc - n0, 1);
        wait_hpc(2500);
        check({seen, rst_seen, pwr.battery_switch, spg}, 4'hF);
        check(pwr.rail_en, rcfg);
        $display("long press reset test done");
        vin(2);
        check(seen, 1'b0);
        vin(4);
        check(seen, 1'b0);
        vin(3);
        check(seen, 1'b1);
        $display("input pulse test done");
        {wd_en, ack_en, pgs} = 3'h7;
        wait_hpc(4000);
        check(seen, 1'b0);
        {pgs, ack_en, need_in} = 3'h1;
        tick(2);
        {pgs, pg} = 2'h2;
        wait_hpc(4000);
        check(seen, 1'b0);
        pg = 1'b1;
        wait_hpc(1000);
        check(seen, 1'b1);
        {wd_en, pgs, need_in} = 3'h0;
        $display("watchdog test done");
        rnd = lfsr(rnd);
        {act, pb} = {{2{rnd[6]}}, 1'b0};
        wait_hpc(240);
        pb = 1'b1;
        check({seen, ship}, 2'h0);
        tick(20);
        srq = 1'b1;
        tick(1);
        srq = 1'b0;
        check(sstb, 1'b1);
        tick(1);
        check(sstb, 1'b0);
        {act, pg, pb} = {pbm_pkg::LP_SHIP, 2'h0};
        tick(180);
        pb = 1'b1;
        tick(600);
        check(ship, 1'b1);
        check({pwr.system_rail_pulldown, pwr.battery_switch, pwr.rail_en}, 6'h20);
        {bat_ok, pb} = 2'h0;
        tick(260);
        check(ship, 1'b1);
        pg = 1'b1;
        tick(3);
        check(ship, 1'b0);
        {bat_ok, pb, pg, msk.warn, n0} = {4'hD, pc};
        tick(20);
        pb = 1'b0;
        tick(180);
        pb = 1'b1;
        check(pc - n0, 0);
        tick(600);
        check(ship, 1'b1);
        {dep, pb} = 2'h2;
        tick(260);
        check({ship, pwr.battery_switch, pwr.input_switch}, 3'h0);
        pb = 1'b1;
        $display("ship test done");
        tick(600);
        stop_test();
    end
endmodule // test_pbm_wake_manager
